// >>> rtl/hsd_axil.sv
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module hsd_axil
  import hsd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write address and data
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  output logic wr_req,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_req,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  typedef struct packed
  {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_got;
    logic [7:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsd_axi_st_t;

  hsd_axi_st_t s_r;
  hsd_axi_st_t s_nxt;

  assign s_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_wready = !s_r.w_got && !s_r.bvalid;
  assign s_arready = !s_r.ar_got && !s_r.rvalid;
  assign wr_req = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign rd_req = s_r.ar_got && !s_r.rvalid;

  always_comb
  begin
    s_nxt = s_r;
    if (s_awvalid && s_awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_wdata;
      s_nxt.wstrb = s_wstrb;
    end
    if (wr_req)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_err ? HSD_RESP_SLVERR : HSD_RESP_OKAY;
    end
    else if (s_r.bvalid && s_bready)
      s_nxt.bvalid = 1'b0;
    if (s_arvalid && s_arready)
    begin
      s_nxt.ar_got = 1'b1;
      s_nxt.araddr = s_araddr;
    end
    if (rd_req)
    begin
      s_nxt.ar_got = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = rd_err ? HSD_RESP_SLVERR : HSD_RESP_OKAY;
    end
    else if (s_r.rvalid && s_rready)
      s_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign wr_addr = s_r.awaddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;
  assign rd_addr = s_r.araddr;
  assign s_bvalid = s_r.bvalid;
  assign s_bresp = s_r.bresp;
  assign s_rvalid = s_r.rvalid;
  assign s_rdata = s_r.rdata;
  assign s_rresp = s_r.rresp;
endmodule // hsd_axil

// >>> rtl/hsd_global_ctrl.sv
// Global control of the high-speed device port: address, attach, frames
//
// Function
// - Address reads zero after reset, bus reset
// - Enabled: match stored address, else zero
// - Address enable cleared by reset, bus reset
// - Enable zero resets controller, transceiver off
// - Detach one: detach, transceiver suspend low
// - Detach zero: D+ pull-up on, attached; the code turns the pull-up on only while enable is one
// - Wakeup write one requests, zero ignored
// - Resume only after 5 ms suspend
// - Wakeup request cleared when resume ends
// - Pull-down disable drives both pull-downs zero
// - Pull-down disable plus detach: lines float
// - Microframe counts 0..7, zero per frame
// - Eight microframes of 125 us each
// - Frame number from last good SOF
// - Bit 31 flags corrupted frame number
// - Error flag updated with start event
// - Event enable bits read and write
// - Bus reset forces end-of-reset enable
// - Endpoint 0..6 enables in bits 8..14
// - Each DMA channel has own enable
// - Suspend after 3 ms idle J
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module hsd_global_ctrl
  import hsd_pkg::*;
#(
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] SUSP_CYC = hsd_pkg::HSD_SUSP_CYC,
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] RSM_WAIT_CYC =
    hsd_pkg::HSD_RSM_WAIT_CYC,
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] RSM_DRIVE_CYC =
    hsd_pkg::HSD_RSM_DRIVE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Packet decoder events
  input wire logic bus_reset,
  input wire logic sof_pulse,
  input wire logic usof_pulse,
  input wire logic [10:0] sof_frame,
  input wire logic sof_crc_err,
  input wire logic tok_valid,
  input wire logic [6:0] tok_addr,
  output logic tok_accept,
  // Event flags of the status logic
  input wire logic [31:0] evt_pending,
  output logic irq,
  // Transceiver line state, asynchronous
  input wire logic line_idle_j,
  // Transceiver control
  output logic ctrl_reset,
  output logic phy_enable,
  output logic phy_suspend_n,
  output logic dp_pullup,
  output logic dp_pulldown,
  output logic dm_pulldown,
  output logic pad_hiz,
  output logic resume_drive,
  // Event pulses and suspend state to the status logic
  output logic suspend_event,
  output logic remote_resume_event,
  output logic suspended
);
  // ==========================================================
  // State
  typedef struct packed
  {
    logic [HSD_ADDR_W-1:0] addr;
    logic addr_en;
    logic en;
    logic detach;
    logic wake_req;
    logic pulldown_disable;
    logic [HSD_FRAME_W-1:0] frame;
    logic [HSD_MICRO_W-1:0] micro;
    logic ferr;
    logic [31:0] ien;
    logic tok_acc;
    logic irq;
    logic idle_s1;
    logic idle_s2;
    logic suspended;
    logic susp_evt;
    logic rsm_active;
    logic rsm_evt;
  } hsd_st_t;

  hsd_st_t s_r;
  hsd_st_t s_nxt;

  logic wr_req;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_req;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic susp_done;
  logic wait_done;
  logic drive_done;
  logic [31:0] ctrl_word;
  logic [31:0] fnum_word;
  logic [31:0] merged;

  // ==========================================================
  // Decode helpers
  function automatic logic hsd_mapped(input logic [7:0] a);
    hsd_mapped = (a == HSD_OFS_CTRL) || (a == HSD_OFS_FNUM) ||
      (a == HSD_OFS_IEN);
  endfunction

  function automatic logic [31:0] hsd_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    end
    hsd_merge = m;
  endfunction

  // ==========================================================
  // Bus front end
  hsd_axil u_axil (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_req(wr_req),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ==========================================================
  // Register words
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[HSD_ADDR_LSB +: HSD_ADDR_W] = s_r.addr;
    ctrl_word[HSD_ADDR_EN_BIT] = s_r.addr_en;
    ctrl_word[HSD_EN_BIT] = s_r.en;
    ctrl_word[HSD_DETACH_BIT] = s_r.detach;
    ctrl_word[HSD_WAKE_BIT] = s_r.wake_req;
    ctrl_word[HSD_PULLD_BIT] = s_r.pulldown_disable;
    fnum_word = HSD_FNUM_RST;
    fnum_word[HSD_MICRO_LSB +: HSD_MICRO_W] = s_r.micro;
    fnum_word[HSD_FRAME_LSB +: HSD_FRAME_W] = s_r.frame;
    fnum_word[HSD_FERR_BIT] = s_r.ferr;
  end

  assign wr_err = !hsd_mapped(wr_addr);
  assign rd_err = !hsd_mapped(rd_addr);

  always_comb
  begin
    rd_data = '0;
    case (rd_addr)
      HSD_OFS_CTRL: rd_data = ctrl_word;
      HSD_OFS_FNUM: rd_data = fnum_word;
      HSD_OFS_IEN: rd_data = s_r.ien;
      default: rd_data = '0;
    endcase
  end

  // ==========================================================
  // Suspend and upstream resume timing
  // Timers restart whenever their condition drops, so a glitch-free
  // line is needed for the whole interval.
  hsd_timer #(.LIMIT(SUSP_CYC)) u_susp_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(s_r.idle_s2 && s_r.en),
    .done(susp_done)
  );

  hsd_timer #(.LIMIT(RSM_WAIT_CYC)) u_wait_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(s_r.suspended),
    .done(wait_done)
  );

  hsd_timer #(.LIMIT(RSM_DRIVE_CYC)) u_drive_tmr (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(s_r.rsm_active),
    .done(drive_done)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    merged = hsd_merge(ctrl_word, wr_data, wr_strb);
    s_nxt.idle_s1 = line_idle_j;
    s_nxt.idle_s2 = s_r.idle_s1;
    s_nxt.susp_evt = 1'b0;
    s_nxt.rsm_evt = 1'b0;

    // Suspend state follows the idle timer
    s_nxt.suspended = susp_done;
    if (susp_done && !s_r.suspended)
      s_nxt.susp_evt = 1'b1;

    // Resume signalling ends first so a new write can still win
    if (s_r.rsm_active && drive_done)
    begin
      s_nxt.rsm_active = 1'b0;
      s_nxt.wake_req = 1'b0;
    end
    else if (s_r.wake_req && wait_done && !s_r.rsm_active)
    begin
      s_nxt.rsm_active = 1'b1;
      s_nxt.rsm_evt = 1'b1;
    end

    // Software writes
    if (wr_req)
    begin
      case (wr_addr)
        HSD_OFS_CTRL:
        begin
          s_nxt.addr = merged[HSD_ADDR_LSB +: HSD_ADDR_W];
          s_nxt.addr_en = merged[HSD_ADDR_EN_BIT];
          s_nxt.en = merged[HSD_EN_BIT];
          s_nxt.detach = merged[HSD_DETACH_BIT];
          s_nxt.pulldown_disable = merged[HSD_PULLD_BIT];
          if (wr_strb[HSD_WAKE_BIT / 8] && wr_data[HSD_WAKE_BIT])
            s_nxt.wake_req = 1'b1;
        end
        HSD_OFS_IEN:
          s_nxt.ien = hsd_merge(s_r.ien, wr_data, wr_strb) &
            (HSD_IEN_EVT_MASK | HSD_IEN_EPT_MASK |
            HSD_IEN_DMA_MASK);
        default:
          s_nxt.ien = s_nxt.ien;
      endcase
    end

    // Frame tracking; the two start events never coincide
    if (s_r.en && sof_pulse)
    begin
      s_nxt.ferr = sof_crc_err;
      if (!sof_crc_err)
      begin
        s_nxt.frame = sof_frame;
        s_nxt.micro = '0;
      end
    end
    else if (s_r.en && usof_pulse)
    begin
      s_nxt.ferr = sof_crc_err;
      // Wraps after HSD_MICRO_PER_FRAME steps
      s_nxt.micro = s_r.micro + 1'b1;
    end

    // Bus reset beats a write in the same cycle
    if (bus_reset)
    begin
      s_nxt.addr = '0;
      s_nxt.addr_en = 1'b0;
      s_nxt.ien[HSD_IEN_ENDRST_BIT] = 1'b1;
    end

    // Disabled controller holds its bus-facing state in reset
    if (!s_nxt.en)
    begin
      s_nxt.addr = '0;
      s_nxt.addr_en = 1'b0;
      s_nxt.frame = '0;
      s_nxt.micro = '0;
      s_nxt.ferr = 1'b0;
      s_nxt.wake_req = 1'b0;
      s_nxt.rsm_active = 1'b0;
    end

    // Token filter
    s_nxt.tok_acc = tok_valid && s_r.en &&
      (tok_addr == (s_r.addr_en ? s_r.addr : '0));

    s_nxt.irq = |(evt_pending & s_r.ien);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.en <= HSD_CTRL_RST[HSD_EN_BIT];
      s_r.detach <= HSD_CTRL_RST[HSD_DETACH_BIT];
      s_r.ien <= HSD_IEN_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Outputs
  assign tok_accept = s_r.tok_acc;
  assign irq = s_r.irq;
  assign ctrl_reset = !s_r.en;
  assign phy_enable = s_r.en;
  assign phy_suspend_n = !s_r.detach;
  assign dp_pullup = s_r.en && !s_r.detach;
  assign dp_pulldown = !s_r.pulldown_disable;
  assign dm_pulldown = !s_r.pulldown_disable;
  assign pad_hiz = s_r.pulldown_disable && s_r.detach;
  assign resume_drive = s_r.rsm_active;
  assign suspend_event = s_r.susp_evt;
  assign remote_resume_event = s_r.rsm_evt;
  assign suspended = s_r.suspended;
endmodule // hsd_global_ctrl

// >>> rtl/hsd_pkg.sv
// Constants, register map and field layout of the device global control slice
package hsd_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] HSD_OFS_CTRL = 8'h00;
  localparam logic [7:0] HSD_OFS_FNUM = 8'h04;
  localparam logic [7:0] HSD_OFS_IEN = 8'h10;
  // ==========================================================
  // Reset values
  localparam logic [31:0] HSD_CTRL_RST = 32'h0000_0200;
  localparam logic [31:0] HSD_FNUM_RST = 32'h0000_0000;
  localparam logic [31:0] HSD_IEN_RST = 32'h0000_0010;
  // ==========================================================
  // Control fields
  localparam int HSD_ADDR_W = 7;
  localparam int HSD_ADDR_LSB = 0;
  localparam int HSD_ADDR_EN_BIT = 7;
  localparam int HSD_EN_BIT = 8;
  localparam int HSD_DETACH_BIT = 9;
  localparam int HSD_WAKE_BIT = 10;
  localparam int HSD_PULLD_BIT = 11;
  // ==========================================================
  // Frame number fields
  localparam int HSD_MICRO_W = 3;
  localparam int HSD_MICRO_LSB = 0;
  localparam int HSD_FRAME_W = 11;
  localparam int HSD_FRAME_LSB = 3;
  localparam int HSD_FERR_BIT = 31;
  localparam int HSD_MICRO_PER_FRAME = 8;
  localparam int HSD_MICRO_US = 125;
  // ==========================================================
  // Interrupt enable fields
  localparam int HSD_IEN_ENDRST_BIT = 4;
  localparam logic [31:0] HSD_IEN_EVT_MASK = 32'h0000_00FE;
  localparam logic [31:0] HSD_IEN_EPT_MASK = 32'h0000_7F00;
  localparam logic [31:0] HSD_IEN_DMA_MASK = 32'h7E00_0000;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] HSD_RESP_OKAY = 2'h0;
  localparam logic [1:0] HSD_RESP_SLVERR = 2'h2;
  // ==========================================================
  // Timing
  localparam int HSD_CLK_KHZ = 40000;
  localparam int HSD_SUSP_IDLE_MS = 3;
  localparam int HSD_RSM_WAIT_MS = 5;
  localparam int HSD_RSM_DRIVE_MS = 2;
  localparam int HSD_TMR_W = 20;
  localparam logic [HSD_TMR_W-1:0] HSD_SUSP_CYC =
    HSD_TMR_W'(HSD_SUSP_IDLE_MS * HSD_CLK_KHZ);
  localparam logic [HSD_TMR_W-1:0] HSD_RSM_WAIT_CYC =
    HSD_TMR_W'(HSD_RSM_WAIT_MS * HSD_CLK_KHZ);
  localparam logic [HSD_TMR_W-1:0] HSD_RSM_DRIVE_CYC =
    HSD_TMR_W'(HSD_RSM_DRIVE_MS * HSD_CLK_KHZ);
endpackage

// >>> rtl/hsd_timer.sv
// Saturating duration timer: done while run has held for limit plus one cycles
`timescale 1ns/1ps
module hsd_timer
  import hsd_pkg::*;
#(
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] LIMIT = hsd_pkg::HSD_SUSP_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  output logic done
);
  typedef struct packed
  {
    logic [HSD_TMR_W-1:0] cnt;
    logic done;
  } hsd_tmr_st_t;

  hsd_tmr_st_t s_r;
  hsd_tmr_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (!run)
    begin
      s_nxt.cnt = '0;
      s_nxt.done = 1'b0;
    end
    else if (s_r.cnt != LIMIT)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else
    begin
      s_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign done = s_r.done;
endmodule // hsd_timer

// >>> test/hsd_global_ctrl_bench.sv
// Self-checking bench of the global control slice
`timescale 1ns/1ps
module hsd_global_ctrl_bench;
  import hsd_pkg::*;
  logic clk, sys_rst, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, evt_pending, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic bus_reset, sof_pulse, usof_pulse, sof_crc_err, tok_valid, tok_accept;
  logic [10:0] sof_frame;
  logic [6:0] tok_addr, pv;
  logic line_idle_j, irq, ctrl_reset, phy_enable, phy_suspend_n, dp_pullup;
  logic dp_pulldown, dm_pulldown, pad_hiz, resume_drive, suspended;
  logic suspend_event, remote_resume_event;
  int failures, tests_run;
  assign pv = {ctrl_reset, phy_enable, phy_suspend_n, dp_pullup, dp_pulldown,
    dm_pulldown, pad_hiz};
  // ========
  // Shortened timers keep the run brief
  hsd_global_ctrl #(.SUSP_CYC(20'h14), .RSM_WAIT_CYC(20'h1E),
    .RSM_DRIVE_CYC(20'h0A)) u_hsd_global_ctrl (.clk, .sys_rst, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .bus_reset, .sof_pulse,
    .usof_pulse, .sof_frame, .sof_crc_err, .tok_valid, .tok_addr,
    .tok_accept, .evt_pending, .irq, .line_idle_j, .ctrl_reset, .phy_enable,
    .phy_suspend_n, .dp_pullup, .dp_pulldown, .dm_pulldown, .pad_hiz,
    .resume_drive, .suspend_event, .remote_resume_event, .suspended);
  hsd_host_model u_hsd_host_model (.clk, .bus_reset, .sof_pulse, .usof_pulse,
    .sof_frame, .sof_crc_err, .tok_valid, .tok_addr, .line_idle_j);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ========
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    chk(rd, e);
  endtask
  task automatic tok(input logic [6:0] a, input logic e);
    u_hsd_host_model.ev(3, {4'h0, a}, 1'b0);
    #1 chk({31'h0, tok_accept}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR %0t ns: watchdog expired", $time);
    report_and_stop;
  end
  // ========
  // Main sequence
  initial
  begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = 52'h0;
    evt_pending = 32'h0;
    failures = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    s_wstrb <= 4'hF;
    rchk(HSD_OFS_CTRL, 32'h0000_0200);
    rchk(HSD_OFS_FNUM, 32'h0000_0000);
    rchk(HSD_OFS_IEN, 32'h0000_0010);
    chk({25'h0, pv}, 32'h46);
    rchk(8'h08, 32'h0);
    chk({30'h0, rsp}, {30'h0, HSD_RESP_SLVERR});
    wr(8'h08, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, HSD_RESP_SLVERR});
    wr(HSD_OFS_CTRL, 32'h100);
    rchk(HSD_OFS_CTRL, 32'h100);
    chk({25'h0, pv}, 32'h3E);
    tok(7'h00, 1'b1);
    tok(7'h25, 1'b0);
    wr(HSD_OFS_CTRL, 32'h1A5);
    rchk(HSD_OFS_CTRL, 32'h1A5);
    tok(7'h25, 1'b1);
    tok(7'h00, 1'b0);
    wr(HSD_OFS_IEN, 32'hFFFF_FFFF);
    rchk(HSD_OFS_IEN, 32'h7E00_7FFE);
    wr(HSD_OFS_IEN, 32'h0);
    rchk(HSD_OFS_IEN, 32'h0);
    u_hsd_host_model.ev(0, 11'h0, 1'b0);
    rchk(HSD_OFS_CTRL, 32'h100);
    rchk(HSD_OFS_IEN, 32'h10);
    u_hsd_host_model.ev(1, 11'h123, 1'b0);
    rchk(HSD_OFS_FNUM, 32'h918);
    for (int i = 1; i < 9; i++)
    begin
      u_hsd_host_model.ev(2, 11'h0, 1'b0);
      rchk(HSD_OFS_FNUM, 32'h918 | (i % 8));
    end
    u_hsd_host_model.ev(2, 11'h0, 1'b1);
    rchk(HSD_OFS_FNUM, 32'h8000_0919);
    u_hsd_host_model.ev(1, 11'h7FF, 1'b0);
    wr(HSD_OFS_FNUM, 32'h0);
    rchk(HSD_OFS_FNUM, 32'h3FF8);
    wr(HSD_OFS_CTRL, 32'h900);
    chk({25'h0, pv}, 32'h38);
    wr(HSD_OFS_CTRL, 32'hB00);
    chk({25'h0, pv}, 32'h21);
    rchk(HSD_OFS_CTRL, 32'hB00);
    wr(HSD_OFS_IEN, 32'h100);
    evt_pending <= 32'h100;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    evt_pending <= 32'h200;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    evt_pending <= 32'h0;
    wr(HSD_OFS_CTRL, 32'h500);
    rchk(HSD_OFS_CTRL, 32'h500);
    u_hsd_host_model.idle(1'b1);
    while (!resume_drive) @(posedge clk);
    while (resume_drive) @(posedge clk);
    rchk(HSD_OFS_CTRL, 32'h100);
    chk({31'h0, suspended}, 32'h1);
    u_hsd_host_model.idle(1'b0);
    wr(HSD_OFS_CTRL, 32'h1A5);
    wr(HSD_OFS_CTRL, 32'h0A5);
    chk({31'h0, suspended}, 32'h0);
    rchk(HSD_OFS_CTRL, 32'h0);
    tok(7'h00, 1'b0);
    report_and_stop;
  end
endmodule // hsd_global_ctrl_bench

// >>> test/hsd_global_ctrl_monitor.sv
// Concurrent checks on the ports of the global control slice
`timescale 1ns/1ps
module hsd_global_ctrl_monitor
  import hsd_pkg::*;
#(
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] SUSP_CYC = hsd_pkg::HSD_SUSP_CYC,
  parameter logic [hsd_pkg::HSD_TMR_W-1:0] RSM_WAIT_CYC =
    hsd_pkg::HSD_RSM_WAIT_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic tok_valid,
  input wire logic tok_accept,
  input wire logic [31:0] evt_pending,
  input wire logic irq,
  input wire logic line_idle_j,
  input wire logic ctrl_reset,
  input wire logic phy_enable,
  input wire logic phy_suspend_n,
  input wire logic dp_pullup,
  input wire logic dp_pulldown,
  input wire logic dm_pulldown,
  input wire logic pad_hiz,
  input wire logic resume_drive,
  input wire logic suspend_event,
  input wire logic remote_resume_event,
  input wire logic suspended
);
  logic [HSD_TMR_W-1:0] idle_cnt_r;
  logic [HSD_TMR_W-1:0] idle_cnt_nxt;
  logic [HSD_TMR_W-1:0] susp_cnt_r;
  logic [HSD_TMR_W-1:0] susp_cnt_nxt;
  // ========
  // Run lengths of idle line and of suspend
  always_comb
  begin
    idle_cnt_nxt = line_idle_j ? idle_cnt_r + 1'b1 : '0;
    susp_cnt_nxt = suspended ? susp_cnt_r + 1'b1 : '0;
  end
  always_ff @(posedge clk)
  begin
    idle_cnt_r <= sys_rst ? '0 : idle_cnt_nxt;
    susp_cnt_r <= sys_rst ? '0 : susp_cnt_nxt;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ========
  // Assertions
  a_enable_reset: assert property (ctrl_reset != phy_enable)
    else $error("controller reset not the inverse of enable");
  a_attach_pullup: assert property
    (dp_pullup |-> phy_enable && phy_suspend_n)
    else $error("pull-up on while detached or disabled");
  a_pulldown_pair: assert property (dp_pulldown == dm_pulldown)
    else $error("pull-down controls differ");
  a_float_pads: assert property
    (pad_hiz |-> !dp_pulldown && !phy_suspend_n)
    else $error("floating pads with pull-down or active transceiver");
  a_token_cause: assert property
    (tok_accept |-> $past(tok_valid) && $past(phy_enable))
    else $error("token accepted without token or while disabled");
  a_idle_suspend: assert property
    ($rose(suspended) |-> idle_cnt_r >= SUSP_CYC)
    else $error("suspend entered before idle time");
  a_suspend_pulse: assert property
    (suspend_event |-> ##[0:1] suspended)
    else $error("suspend event without suspend state");
  a_resume_wait: assert property
    ($rose(resume_drive) |-> susp_cnt_r >= RSM_WAIT_CYC - 2)
    else $error("resume sent before suspend wait");
  a_resume_hold: assert property
    ($rose(resume_drive) |-> resume_drive[*8])
    else $error("resume signalling cut short");
  a_resume_pulse: assert property
    (remote_resume_event |-> ##[0:1] resume_drive)
    else $error("resume event without resume signalling");
  a_irq_cause: assert property
    (irq |-> $past(evt_pending) != 32'h0)
    else $error("interrupt without pending flag");
endmodule // hsd_global_ctrl_monitor

bind hsd_global_ctrl hsd_global_ctrl_monitor #(.SUSP_CYC(SUSP_CYC),
  .RSM_WAIT_CYC(RSM_WAIT_CYC)) u_hsd_global_ctrl_monitor (.clk, .sys_rst,
  .tok_valid, .tok_accept, .evt_pending, .irq, .line_idle_j, .ctrl_reset,
  .phy_enable, .phy_suspend_n, .dp_pullup, .dp_pulldown, .dm_pulldown,
  .pad_hiz, .resume_drive, .suspend_event, .remote_resume_event, .suspended);

// >>> test/hsd_host_model.sv
// Host-side model: bus reset, frame starts, tokens and line state
`timescale 1ns/1ps
module hsd_host_model
(
  // Clock
  input wire logic clk,
  // Host events
  output logic bus_reset,
  output logic sof_pulse,
  output logic usof_pulse,
  output logic [10:0] sof_frame,
  output logic sof_crc_err,
  output logic tok_valid,
  output logic [6:0] tok_addr,
  // Line state
  output logic line_idle_j
);
  // ========
  // Idle values
  initial
  begin
    bus_reset = 1'b0;
    sof_pulse = 1'b0;
    usof_pulse = 1'b0;
    sof_frame = 11'h5A5;
    sof_crc_err = 1'b1;
    tok_valid = 1'b0;
    tok_addr = 7'h55;
    line_idle_j = 1'b0;
  end
  // ========
  // One event: 0 bus reset, 1 frame start, 2 microframe, 3 token
  task automatic ev(input int k, input logic [10:0] v, input logic e);
    @(posedge clk);
    bus_reset <= (k == 0);
    sof_pulse <= (k == 1);
    usof_pulse <= (k == 2);
    tok_valid <= (k == 3);
    sof_frame <= v;
    tok_addr <= v[6:0];
    sof_crc_err <= e;
    @(posedge clk);
    bus_reset <= 1'b0;
    sof_pulse <= 1'b0;
    usof_pulse <= 1'b0;
    tok_valid <= 1'b0;
    // Stale qualifiers are scrambled so nothing leans on them
    sof_frame <= ~v;
    tok_addr <= ~v[6:0];
    sof_crc_err <= ~e;
  endtask
  task automatic idle(input logic v);
    @(posedge clk);
    line_idle_j <= v;
  endtask
endmodule // hsd_host_model
